/* File: design/cpu_state_pkg.sv */
// cpu_state_pkg: field positions, encodings and sizes of processor state
// assumes bit 1 of the documented numbering is the msb of each word
package cpu_state_pkg;
  // addressing-mode encodings
  typedef enum logic [2:0] {
    mode_16s = 3'h0,
    mode_32s = 3'h1,
    mode_32r = 3'h3,
    mode_64r = 3'h2,
    mode_64v = 3'h6,
    mode_32i = 3'h4
  } addr_mode_type;
  // status word (segmented), lsb numbering: doc bit n -> index 16-n
  localparam int unsigned st_error = 15;
  localparam int unsigned st_prec = 14;
  localparam int unsigned st_link = 13;
  localparam int unsigned st_mode_hi = 12;
  localparam int unsigned st_mode_lo = 10;
  localparam int unsigned st_float_en = 9;
  localparam int unsigned st_int_en = 8;
  localparam int unsigned st_neg = 7;
  localparam int unsigned st_zero = 6;
  localparam int unsigned st_dec_en = 5;
  localparam int unsigned st_disp = 1;
  localparam int unsigned st_save = 0;
  // software-writable bits in segmented modes (excludes 2, 12-14, 15, 16)
  localparam logic [15:0] seg_write_mask = 16'hFFE0 & ~16'h4000;
  // short-mode writable bits: error, precision, mode, shift-count mirror
  localparam logic [15:0] short_write_mask = 16'hDCFF;
  // modals fields
  localparam int unsigned md_regset_hi = 7;
  localparam int unsigned md_regset_lo = 5;
  localparam logic [15:0] modals_write_mask = 16'hFF1F;
  localparam logic [15:0] status_reset = 16'h0000;
  localparam logic [15:0] modals_reset = 16'h0000;
  // pointer field masks (zero bits 1 and 4 forced)
  localparam logic [31:0] pointer_mask = 32'h6FFFFFFF;
  // field register: bits 53-59 zero
  localparam logic [63:0] field_mask = {32'h6FFFFFFF, 32'hFFFFF01F};
  localparam int unsigned exp_bias = 128;
  localparam int unsigned shift_zero_count = 63;
  // register-select codes of the state port
  localparam logic [3:0] sel_base0 = 4'h0;
  localparam logic [3:0] sel_fhi0 = 4'h4;
  localparam logic [3:0] sel_flo0 = 4'h5;
  localparam logic [3:0] sel_fhi1 = 4'h6;
  localparam logic [3:0] sel_flo1 = 4'h7;
  localparam logic [3:0] sel_status = 4'h8;
  localparam logic [3:0] sel_modals = 4'h9;
endpackage : cpu_state_pkg

/* File: design/cpu_status_and_register_state.sv */
// cpu_status_and_register_state: general, floating/field, base registers,
// status word and modals, plus instruction field decode and flag update.
// assumes the execution unit supplies results and strobes synchronous to clock
// Behaviour
// - eight 32-bit general registers, 1-7 index
// - two 64-bit float accumulators share field storage
// - single float: sign, mantissa, exponent biased 128
// - four base pointers with ring/segment/word layout
// - field pair: pointer, split length, bit number
// - short status: error, precision, mode, shift mirror
// - mode field uses six fixed three-bit codes
// - segmented status word bit layout
// - float exception faults unless bit seven set
// - integer exception faults only when enabled
// - decimal exception faults only when enabled
// - dispatcher and save bits only via exchange; code also lets a status write made in a short mode set them
// - arithmetic errors and shifts set error flag
// - carry-link takes msb carry except skip ops
// - zero flag from truncated result
// - negative flag from untruncated sign
// - modals word bit layout
// - generic opcode is whole word, bits 3-6 zero
// - shift format: opcode and negated count, 0 means 63
`timescale 1ns/10ps
module cpu_status_and_register_state #(
  parameter int unsigned gr_count = 8,
  parameter int unsigned gr_width = 32
) (
  input wire logic clock,
  input wire logic rst,
  // general register ports
  input wire logic [2:0] gr_read_index,
  output logic [31:0] gr_read_data,
  output logic [31:0] index_value,
  input wire logic gr_write,
  input wire logic [2:0] gr_write_index,
  input wire logic [31:0] gr_write_data,
  // state register port (base, field/float, status, modals)
  input wire logic [3:0] state_select,
  output logic [63:0] state_read_data,
  input wire logic state_write,
  input wire logic [63:0] state_write_data,
  input wire logic status_load,
  input wire logic [15:0] status_load_data,
  input wire logic [15:0] modals_load_data,
  input wire logic exchange_write,
  input wire logic exchange_dispatch,
  input wire logic exchange_save,
  input wire logic [2:0] exchange_regset,
  // arithmetic result update
  input wire logic result_valid,
  input wire logic result_is_shift,
  input wire logic result_is_skip,
  input wire logic [31:0] result_truncated,
  input wire logic result_true_negative,
  input wire logic result_carry,
  input wire logic result_error,
  input wire logic float_exception,
  input wire logic integer_exception,
  input wire logic decimal_exception,
  output logic fault,
  // status decode
  output logic [15:0] status_word,
  output logic [15:0] modals_word,
  output logic precision_flag,
  output logic [2:0] active_register_set,
  output logic mapped_io_bit,
  output logic [1:0] machine_check_field,
  output logic segmented_mode,
  // float decode of accumulator 0
  output logic float_sign,
  output logic [30:0] float_mantissa,
  output logic signed [16:0] float_exponent,
  // field decode of register 0
  output logic [1:0] field_ring,
  output logic [11:0] segment_number,
  output logic [15:0] word_number,
  output logic [20:0] field_length,
  output logic [3:0] bit_number,
  // instruction decode
  input wire logic [15:0] instr_word,
  output logic [15:0] generic_opcode,
  output logic generic_valid,
  output logic [9:0] shift_opcode,
  output logic [5:0] shift_distance
);
  logic [gr_width-1:0] gr_q [gr_count];
  logic [31:0] base_q [4];
  logic [63:0] field_q [2];
  logic [15:0] status_q, status_d;
  logic [15:0] modals_q, modals_d;
  logic fault_q, fault_d;

  // segmented addressing modes are 64v and 32i
  function automatic logic is_segmented(input logic [2:0] mode);
    is_segmented = (mode == cpu_state_pkg::mode_64v) || (mode == cpu_state_pkg::mode_32i);
  endfunction : is_segmented

  // mask applied to software writes depends on addressing mode
  function automatic logic [15:0] write_mask(input logic [2:0] mode);
    write_mask = is_segmented(mode) ? cpu_state_pkg::seg_write_mask : cpu_state_pkg::short_write_mask;
  endfunction : write_mask

  wire [2:0] mode_field = status_q[cpu_state_pkg::st_mode_hi:cpu_state_pkg::st_mode_lo];
  wire seg_mode = is_segmented(mode_field);
  wire is_status_sel = state_write && (state_select == cpu_state_pkg::sel_status);
  wire is_modals_sel = state_write && (state_select == cpu_state_pkg::sel_modals);
  wire [15:0] sw_mask = write_mask(mode_field);

  // general register file, index 0 means no indexing
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < gr_count; i++) gr_q[i] <= '0;
    end else if (gr_write) begin
      gr_q[gr_write_index] <= gr_write_data;
    end
  end
  assign gr_read_data = gr_q[gr_read_index];
  assign index_value = (gr_read_index == 3'h0) ? 32'h00000000 : gr_q[gr_read_index];

  // base pointers and shared field/float storage, zero bits forced except on sel_flo0/sel_flo1 writes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) base_q[i] <= 32'h00000000;
      field_q[0] <= 64'h0000000000000000;
      field_q[1] <= 64'h0000000000000000;
    end else if (state_write) begin
      case (state_select)
        4'h0, 4'h1, 4'h2, 4'h3: base_q[state_select[1:0]] <= state_write_data[31:0] & cpu_state_pkg::pointer_mask;
        cpu_state_pkg::sel_fhi0: field_q[0] <= state_write_data & cpu_state_pkg::field_mask;
        cpu_state_pkg::sel_flo0: field_q[0] <= state_write_data;
        cpu_state_pkg::sel_fhi1: field_q[1] <= state_write_data & cpu_state_pkg::field_mask;
        cpu_state_pkg::sel_flo1: field_q[1] <= state_write_data;
        default: ;
      endcase
    end
  end

  // status word next value: software writes, exchange, then result flags
  always_comb begin
    status_d = status_q;
    fault_d = 1'b0;
    if (status_load || is_status_sel) begin
      status_d = ((status_load ? status_load_data : state_write_data[15:0]) & sw_mask)
        | (status_q & ~sw_mask);
    end
    if (exchange_write) begin
      status_d[cpu_state_pkg::st_disp] = exchange_dispatch;
      status_d[cpu_state_pkg::st_save] = exchange_save;
    end
    if (result_valid) begin
      if (result_error || result_is_shift) status_d[cpu_state_pkg::st_error] = 1'b1;
      if (seg_mode) begin
        if (!result_is_skip) status_d[cpu_state_pkg::st_link] = result_carry;
        status_d[cpu_state_pkg::st_zero] = (result_truncated == 32'h00000000);
        status_d[cpu_state_pkg::st_neg] = result_true_negative;
      end
    end
    if (float_exception) begin
      if (status_q[cpu_state_pkg::st_float_en]) status_d[cpu_state_pkg::st_error] = 1'b1;
      else fault_d = 1'b1;
    end
    if (integer_exception) begin
      if (status_q[cpu_state_pkg::st_int_en]) fault_d = 1'b1;
      else status_d[cpu_state_pkg::st_error] = 1'b1;
    end
    if (decimal_exception && seg_mode) begin
      if (status_q[cpu_state_pkg::st_dec_en]) fault_d = 1'b1;
      else status_d[cpu_state_pkg::st_error] = 1'b1;
    end
    // zero bits follow the mode being entered, so no stale bit survives a switch
    if (is_segmented(status_d[cpu_state_pkg::st_mode_hi:cpu_state_pkg::st_mode_lo])) begin
      status_d[14] = 1'b0;
      status_d[4:2] = 3'h0;
    end
  end

  // modals: register set only from the exchange
  always_comb begin
    modals_d = modals_q;
    if (status_load || is_modals_sel) begin
      modals_d = ((status_load ? modals_load_data : state_write_data[15:0]) & cpu_state_pkg::modals_write_mask)
        | (modals_q & ~cpu_state_pkg::modals_write_mask);
    end
    if (exchange_write) modals_d[cpu_state_pkg::md_regset_hi:cpu_state_pkg::md_regset_lo] = exchange_regset;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_q <= cpu_state_pkg::status_reset;
      modals_q <= cpu_state_pkg::modals_reset;
      fault_q <= 1'b0;
    end else begin
      status_q <= status_d;
      modals_q <= modals_d;
      fault_q <= fault_d;
    end
  end

  // readback mux
  always_comb begin
    case (state_select)
      4'h0, 4'h1, 4'h2, 4'h3: state_read_data = {32'h00000000, base_q[state_select[1:0]]};
      cpu_state_pkg::sel_fhi0, cpu_state_pkg::sel_flo0: state_read_data = field_q[0];
      cpu_state_pkg::sel_fhi1, cpu_state_pkg::sel_flo1: state_read_data = field_q[1];
      cpu_state_pkg::sel_status: state_read_data = {48'h000000000000, status_q};
      cpu_state_pkg::sel_modals: state_read_data = {48'h000000000000, modals_q};
      default: state_read_data = 64'h0000000000000000;
    endcase
  end

  // status and modals field decode
  assign status_word = status_q;
  assign modals_word = modals_q;
  assign fault = fault_q;
  assign precision_flag = status_q[cpu_state_pkg::st_prec];
  assign segmented_mode = seg_mode;
  assign active_register_set = modals_q[cpu_state_pkg::md_regset_hi:cpu_state_pkg::md_regset_lo];
  assign mapped_io_bit = modals_q[4];
  assign machine_check_field = modals_q[1:0];

  // single-precision view of accumulator 0
  assign float_sign = field_q[0][63];
  assign float_mantissa = field_q[0][62:32];
  assign float_exponent = $signed({1'b0, field_q[0][31:16]}) - 17'(cpu_state_pkg::exp_bias);

  // field register 0 view
  assign field_ring = field_q[0][62:61];
  assign segment_number = field_q[0][59:48];
  assign word_number = field_q[0][47:32];
  assign field_length = {field_q[0][31:16], field_q[0][4:0]};
  assign bit_number = field_q[0][15:12];

  // instruction field decode
  assign generic_opcode = instr_word;
  assign generic_valid = (instr_word[13:10] == 4'h0);
  assign shift_opcode = instr_word[15:6];
  assign shift_distance = (instr_word[5:0] == 6'h00) ? 6'(cpu_state_pkg::shift_zero_count)
    : 6'(-instr_word[5:0]);
endmodule : cpu_status_and_register_state

/* File: verification/cpu_state_monitor.sv */
// cpu_state_monitor: concurrent checks on the state block's ports
// assumes one clock domain with async active-high reset
`timescale 1ns/10ps
module cpu_state_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0] gr_read_index,
  input wire logic [31:0] gr_read_data,
  input wire logic [31:0] index_value,
  input wire logic state_write,
  input wire logic status_load,
  input wire logic exchange_write,
  input wire logic result_valid,
  input wire logic result_is_skip,
  input wire logic [31:0] result_truncated,
  input wire logic result_true_negative,
  input wire logic result_carry,
  input wire logic float_exception,
  input wire logic integer_exception,
  input wire logic decimal_exception,
  input wire logic fault,
  input wire logic [15:0] status_word,
  input wire logic segmented_mode,
  input wire logic [15:0] instr_word,
  input wire logic generic_valid,
  input wire logic [5:0] shift_distance
);
  logic [5:0] neg_count;
  // negated shift field
  assign neg_count = 6'h0 - instr_word[5:0];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // no software write or result competing with the event
  sequence s_quiet; !result_valid && !status_load && !state_write; endsequence
  sequence s_one_exc; s_quiet ##0 (32'(float_exception) + integer_exception + decimal_exception == 1); endsequence
  property p_index; index_value == ((gr_read_index == 3'h0) ? 32'h0 : gr_read_data); endproperty
  a_index: assert property (p_index) else $error("index value wrong");
  property p_float; s_one_exc ##0 float_exception |=> fault != $past(status_word[9]) && (fault || status_word[15]);
  endproperty
  a_float: assert property (p_float) else $error("float exception handling wrong");
  property p_int; s_one_exc ##0 integer_exception |=> fault == $past(status_word[8]) && (fault || status_word[15]);
  endproperty
  a_int: assert property (p_int) else $error("integer exception handling wrong");
  property p_dec; s_one_exc ##0 (decimal_exception && segmented_mode) |=>
    fault == $past(status_word[5]) && (fault || status_word[15]); endproperty
  a_dec: assert property (p_dec) else $error("decimal exception handling wrong");
  property p_zero_bits; segmented_mode |-> status_word[4:2] == 3'h0 && !status_word[14]; endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("reserved status bit set");
  property p_link; result_valid && !result_is_skip && segmented_mode |=> status_word[13] == $past(result_carry);
  endproperty
  a_link: assert property (p_link) else $error("carry link wrong");
  property p_cond; result_valid && segmented_mode && !status_load && !state_write |=>
    status_word[6] == ($past(result_truncated) == 32'h0) && status_word[7] == $past(result_true_negative); endproperty
  a_cond: assert property (p_cond) else $error("condition codes wrong");
  property p_exchange; segmented_mode && !exchange_write |=> status_word[1:0] == $past(status_word[1:0]);
  endproperty
  a_exchange: assert property (p_exchange) else $error("dispatcher bits changed");
  property p_decode; shift_distance == ((instr_word[5:0] == 6'h0) ? 6'h3F : neg_count) &&
    generic_valid == (instr_word[13:10] == 4'h0); endproperty
  a_decode: assert property (p_decode) else $error("instruction decode wrong");
endmodule : cpu_state_monitor
bind cpu_status_and_register_state cpu_state_monitor mon_u (.clock, .rst, .gr_read_index, .gr_read_data,
  .index_value, .state_write, .status_load, .exchange_write, .result_valid, .result_is_skip, .result_truncated,
  .result_true_negative, .result_carry, .float_exception, .integer_exception, .decimal_exception, .fault,
  .status_word, .segmented_mode, .instr_word, .generic_valid, .shift_distance);

/* File: verification/tb_cpu_status_and_register_state.sv */
// tb_cpu_status_and_register_state: random and corner stimulus with self-checks
// assumes the state block alone on a 50 MHz clock with async high reset
`timescale 1ns/10ps
module tb_cpu_status_and_register_state;
  logic clock = 1'b0, rst = 1'b1, gr_write = 1'b0, state_write = 1'b0, status_load = 1'b0, exchange_write = 1'b0;
  logic exchange_dispatch = 1'b0, exchange_save = 1'b0, result_valid = 1'b0, result_is_shift = 1'b0;
  logic result_is_skip = 1'b0, result_true_negative = 1'b0, result_carry = 1'b0, result_error = 1'b0;
  logic float_exception = 1'b0, integer_exception = 1'b0, decimal_exception = 1'b0;
  logic [2:0] gr_read_index = '0, gr_write_index = '0, exchange_regset = '0;
  logic [3:0] state_select = '0;
  logic [15:0] status_load_data = '0, modals_load_data = '0, instr_word = '0;
  logic [31:0] gr_write_data = '0, result_truncated = '0;
  logic [63:0] state_write_data = '0;
  logic fault, mapped_io_bit, segmented_mode, generic_valid, precision_flag, float_sign;
  logic [30:0] float_mantissa;
  logic signed [16:0] float_exponent;
  logic [1:0] field_ring;
  logic [15:0] word_number;
  logic [1:0] machine_check_field;
  logic [2:0] active_register_set;
  logic [3:0] bit_number;
  logic [5:0] shift_distance;
  logic [9:0] shift_opcode;
  logic [11:0] segment_number;
  logic [15:0] status_word, modals_word, generic_opcode, m, ex;
  logic [20:0] field_length;
  logic [31:0] gr_read_data, index_value;
  logic [63:0] state_read_data, d;
  logic lk;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
  logic [3:0] sels [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6};
  int mismatches = 0, checks_done = 0;
  cpu_status_and_register_state dut_u (.clock, .rst, .gr_read_index, .gr_read_data, .index_value, .gr_write,
    .gr_write_index, .gr_write_data, .state_select, .state_read_data, .state_write, .state_write_data,
    .status_load, .status_load_data, .modals_load_data, .exchange_write, .exchange_dispatch, .exchange_save,
    .exchange_regset, .result_valid, .result_is_shift, .result_is_skip, .result_truncated, .result_true_negative,
    .result_carry, .result_error, .float_exception, .integer_exception, .decimal_exception, .fault, .status_word,
    .modals_word, .precision_flag, .active_register_set, .mapped_io_bit, .machine_check_field, .segmented_mode,
    .float_sign, .float_mantissa, .float_exponent, .field_ring, .segment_number, .word_number,
    .field_length, .bit_number, .instr_word, .generic_opcode, .generic_valid, .shift_opcode, .shift_distance);
  task automatic check(input string n, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  // captures the strobes, drops them and waits for settled outputs
  task automatic settle;
    @(posedge clock);
    {gr_write, state_write, status_load, exchange_write, result_valid} <= '0;
    {float_exception, integer_exception, decimal_exception} <= '0;
    @(negedge clock);
  endtask : settle
  task automatic load(input logic [15:0] s, input logic [15:0] md);
    @(posedge clock);
    status_load <= 1'b1;
    status_load_data <= s;
    modals_load_data <= md;
    settle;
  endtask : load
  task automatic final_report;
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial begin
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    final_report;
  end
  initial begin
    d[31:0] = $urandom(32'h363aa459);
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    // general registers written then read back
    for (int i = 0; i < 8; i++) begin
      d = {$urandom, $urandom};
      @(posedge clock);
      gr_write <= 1'b1;
      gr_write_index <= 3'(i);
      gr_read_index <= 3'(i);
      gr_write_data <= d[31:0];
      settle;
      check("gr_read_data", gr_read_data, d[31:0]);
      check("index_value", index_value, (i == 0) ? 32'h0 : d[31:0]);
    end
    // base and field registers with their zero bits
    foreach (sels[j]) begin
      d = {$urandom, $urandom};
      @(posedge clock);
      state_write <= 1'b1;
      state_select <= sels[j];
      state_write_data <= d;
      settle;
      if (j < 4) check("base", state_read_data[31:0], d[31:0] & cpu_state_pkg::pointer_mask);
      else check("field", state_read_data, d & cpu_state_pkg::field_mask);
      if (j == 4) check("fields", {segment_number, field_length, bit_number}, {d[59:48], d[31:16], d[4:0], d[15:12]});
      if (j == 4) check("ring_word", {field_ring, word_number}, {d[62:61], d[47:32]});
      if (j == 4) check("float", {float_sign, float_mantissa, float_exponent}, {1'b0, d[62:32], 17'({1'b0, d[31:16]}) - 17'h00080});
    end
    // every addressing mode through load-status
    foreach (modes[k]) begin
      m = (16'($urandom) & 16'hE3FC) | {3'h0, modes[k], 10'h0};
      ex = modes[k][2] ? cpu_state_pkg::seg_write_mask : cpu_state_pkg::short_write_mask;
      d[15:0] = 16'($urandom);
      repeat (2) load(m, d[15:0]);
      check("status_word", status_word, m & ex);
      check("segmented_mode", segmented_mode, modes[k][2]);
      check("precision_flag", precision_flag, m[14] && !modes[k][2]);
      check("modals_word", modals_word, d[15:0] & cpu_state_pkg::modals_write_mask);
      check("modal fields", {mapped_io_bit, machine_check_field}, {d[4], d[1:0]});
    end
    // exchange sets dispatcher, save and register set; load-status keeps them
    @(posedge clock);
    exchange_write <= 1'b1;
    {exchange_dispatch, exchange_save, exchange_regset} <= 5'h1D;
    settle;
    load(16'hFBFF, 16'hFFFF);
    check("status after exchange", {status_word, active_register_set}, {16'hBBE3, 3'h5});
    check("modals after exchange", modals_word, 16'hFFBF);
    // random arithmetic and shift results
    lk = 1'b1;
    repeat (24) begin
      d = {$urandom, $urandom};
      @(posedge clock);
      result_valid <= 1'b1;
      {result_is_shift, result_is_skip, result_true_negative, result_carry, result_error} <= d[36:32];
      result_truncated <= (d[39:38] == 2'h0) ? 32'h0 : d[31:0];
      settle;
      if (!d[35]) lk = d[33];
      check("link", status_word[13], lk);
      check("cond", status_word[7:6], {d[34], d[39:38] == 2'h0 || d[31:0] == 32'h0});
      if (d[36] || d[32]) check("error", status_word[15], 1'b1);
    end
    // each exception kind with its enable clear and set
    for (int k = 0; k < 6; k++) begin
      ex = (k < 2) ? 16'h0200 : (k < 4) ? 16'h0100 : 16'h0020;
      load((k[0] ? ex : 16'h0) | 16'h1800, 16'h0);
      @(posedge clock);
      {float_exception, integer_exception, decimal_exception} <= 3'b100 >> (k / 2);
      settle;
      check("fault", fault, k[0] ^ (k < 2));
      check("error", status_word[15], !(k[0] ^ (k < 2)));
    end
    // instruction field decode, corners then random words
    for (int k = 0; k < 20; k++) begin
      m = (k == 0) ? 16'h0000 : (k == 1) ? 16'hC03F : 16'($urandom);
      @(posedge clock);
      instr_word <= m;
      @(negedge clock);
      check("generic", {generic_opcode, generic_valid}, {m, m[13:10] == 4'h0});
      check("shift", {shift_opcode, shift_distance}, {m[15:6], (m[5:0] == 6'h0) ? 6'h3F : 6'h0 - m[5:0]});
    end
    final_report;
  end
endmodule : tb_cpu_status_and_register_state
